// *** rtl/tip_carrier.sv ***
`timescale 1ns/10ps
`include "tip_cfg.svh"

module tip_carrier (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Fast oscillator tick and settings
  input wire logic fosc_tick_in,
  input wire tip_pkg::tip_ir_cfg_s cfg_in,
  input wire logic pin_data_in,
  // Gated carrier
  output logic carrier_out
);
  import tip_pkg::*;

  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic wave;
  logic next_wave;
  logic next_carrier;
  logic [6:0] half;

  always_comb begin
    half = cfg_in.rate_57k ? `TIP_IR_HALF_57K : `TIP_IR_HALF_38K;
    next_cnt = cnt;
    next_wave = wave;
    if (!cfg_in.enable) begin
      next_cnt = 7'h00;
      next_wave = 1'b0;
    end else if (fosc_tick_in) begin
      if (cnt >= half) begin
        next_cnt = 7'h00;
        next_wave = ~wave;
      end else begin
        next_cnt = cnt + 7'h01;
      end
    end
    // Polarity picks which pin level lets the carrier through
    next_carrier = cfg_in.enable & wave & (pin_data_in ^ cfg_in.polarity);
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      cnt <= 7'h00;
      wave <= 1'b0;
      carrier_out <= 1'b0;
    end else begin
      cnt <= next_cnt;
      wave <= next_wave;
      carrier_out <= next_carrier;
    end
  end

endmodule // tip_carrier

// *** rtl/tip_cfg.svh ***
`ifndef TIP_CFG_SVH
`define TIP_CFG_SVH

// Register offsets (5-bit address, 8-bit data)
`define TIP_ADDR_W 5
`define TIP_OFS_RELOAD 5'h00
`define TIP_OFS_TCTRL 5'h01
`define TIP_OFS_TCLK 5'h02
`define TIP_OFS_TONE 5'h05
`define TIP_OFS_IR 5'h06
`define TIP_OFS_P2CTL 5'h0a
`define TIP_OFS_P2DUTY 5'h0c
`define TIP_OFS_THIGH 5'h10
`define TIP_OFS_P3CTL 5'h11
`define TIP_OFS_P3DUTY 5'h13
`define TIP_OFS_P3DHI 5'h14
`define TIP_OFS_STATUS 5'h15

// Field positions
`define TIP_TONE_EN_BIT 7
`define TIP_IR_EN_BIT 0
`define TIP_IR_RATE_BIT 1
`define TIP_IR_POL_BIT 2
`define TIP_PWM_PIN_BIT 7
`define TIP_PWM_AL_BIT 6
`define TIP_FAST_CLK_BIT 3
`define TIP_TC_EN_BIT 0
`define TIP_TC_RL_BIT 1
`define TIP_TC_OS_BIT 2
`define TIP_CLK_CS_BIT 5
`define TIP_CLK_CE_BIT 4
`define TIP_CLK_PSOFF_BIT 3
`define TIP_THIGH_P2D_LSB 2
`define TIP_THIGH_RLD_LSB 4

// Reset values
`define TIP_RST_TONE 8'h0f
`define TIP_RST_ZERO 8'h00
`define TIP_RST_IR 3'h0
`define TIP_RST_P3DHI 2'h0
`define TIP_RST_TCTRL 3'h0
`define TIP_RST_TCLK 6'h3f
`define TIP_RST_PRESC 8'hff
`define TIP_RST_COUNT 10'h000
`define TIP_WRAP_VALUE 10'h3ff

// Timing
`define TIP_MCLK_HZ 10000000
`define TIP_FAST_OSC_HZ 4000000
`define TIP_FOSC_GRAIN 100000
`define TIP_FOSC_STEP 7'((`TIP_FAST_OSC_HZ) / (`TIP_FOSC_GRAIN))
`define TIP_FOSC_MOD 7'((`TIP_MCLK_HZ) / (`TIP_FOSC_GRAIN))
`define TIP_IR_DIV_57K 64
`define TIP_IR_DIV_38K 96
`define TIP_IR_HALF_57K 7'((`TIP_IR_DIV_57K) / 2 - 1)
`define TIP_IR_HALF_38K 7'((`TIP_IR_DIV_38K) / 2 - 1)

`endif

// *** rtl/tip_pkg.sv ***
package tip_pkg;

  typedef enum logic [1:0] {
    TIP_SRC_INSTR,
    TIP_SRC_EXT,
    TIP_SRC_FAST
  } tip_clk_src_e;

  typedef struct packed {
    logic enable;
    logic reload_mode;
    logic one_shot;
    logic presc_off;
    logic [2:0] presc_sel;
    logic [9:0] reload;
  } tip_tmr_cfg_s;

  typedef struct packed {
    logic [9:0] count;
    logic [7:0] presc;
    logic running;
  } tip_tmr_state_s;

  typedef struct packed {
    logic enable;
    logic rate_57k;
    logic polarity;
  } tip_ir_cfg_s;

endpackage

// *** rtl/tip_timer.sv ***
`timescale 1ns/10ps
`include "tip_cfg.svh"

module tip_timer (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Source tick, settings, load strobe
  input wire logic tick_in,
  input wire tip_pkg::tip_tmr_cfg_s cfg_in,
  input wire logic load_in,
  // Counter state
  output tip_pkg::tip_tmr_state_s state_out
);
  import tip_pkg::*;

  logic [7:0] presc;
  logic [7:0] next_presc;
  logic [9:0] count;
  logic [9:0] next_count;
  logic running;
  logic next_running;
  logic [7:0] mask;
  logic step;

  always_comb begin
    mask = 8'((9'h002 << cfg_in.presc_sel) - 9'h001);
    step = 1'b0;
    next_presc = presc;
    next_count = count;
    next_running = running;
    if (load_in) begin
      next_count = cfg_in.reload;
      next_running = 1'b1;
    end else if (cfg_in.enable && tick_in) begin
      if (cfg_in.presc_off) begin
        step = 1'b1;
      end else begin
        next_presc = presc + 8'h01;
        step = ((presc & mask) == mask);
      end
      if (step && running) begin
        if (count == 10'h000) begin
          if (cfg_in.one_shot) begin
            next_running = 1'b0;
          end else if (cfg_in.reload_mode) begin
            next_count = cfg_in.reload;
          end else begin
            next_count = `TIP_WRAP_VALUE;
          end
        end else begin
          next_count = count - 10'h001;
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      presc <= `TIP_RST_PRESC;
      count <= `TIP_RST_COUNT;
      running <= 1'b1;
    end else begin
      presc <= next_presc;
      count <= next_count;
      running <= next_running;
    end
  end

  assign state_out = '{count: count, presc: presc, running: running};

endmodule // tip_timer

// *** rtl/tip_top.sv ***
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`include "tip_cfg.svh"

// Operation
// - Select 0-7 taps prescaler divide 2..256
// - Select 8-15 follows timer bit 0..7
// - Tone driven only while tone enabled
// - Carrier produced only while carrier enabled
// - Rate bit picks 57K or 38K
// - Polarity bit picks pin level gating carrier
// - Carrier clocked only from fast oscillator
// - Carrier divides 4MHz by 64 or 96
// - Fast-clock bit clocks timer and PWMs
// - Second PWM active-low bit inverts output
// - Second PWM pin enable routes to B0
// - Second PWM duty from high bits and register
// - Third PWM active-low bit inverts output
// - Third PWM pin enable routes to B3
// - Source bit picks instruction or external clock
// - Timer reload sets both PWM periods
module tip_top (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [`TIP_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Timer clock sources
  input wire logic instr_clk_en_in,
  input wire logic ext_clk_in,
  // Port data gating the carrier
  input wire logic ir_pin_data_in,
  // Tone on port pin B2
  output logic port_pin_b2_out,
  output logic port_pin_b2_sel_out,
  // Infrared carrier
  output logic carrier_out,
  // Second PWM on port pin B0
  output logic port_pin_b0_out,
  output logic port_pin_b0_sel_out,
  // Third PWM on port pin B3
  output logic port_pin_b3_out,
  output logic port_pin_b3_sel_out
);
  import tip_pkg::*;

  localparam int NUM_PWM = 2;

  // Software-visible registers
  logic [7:0] tone_control;
  logic [7:0] next_tone_control;
  logic [2:0] infrared_carrier_control;
  logic [2:0] next_infrared_carrier_control;
  logic [7:0] second_pwm_control;
  logic [7:0] next_second_pwm_control;
  logic [7:0] second_pwm_duty_low;
  logic [7:0] next_second_pwm_duty_low;
  logic [7:0] third_pwm_control;
  logic [7:0] next_third_pwm_control;
  logic [7:0] third_pwm_duty_low;
  logic [7:0] next_third_pwm_duty_low;
  logic [1:0] third_pwm_duty_high;
  logic [1:0] next_third_pwm_duty_high;
  logic [7:0] timer_high_bits;
  logic [7:0] next_timer_high_bits;
  logic [7:0] timer_reload_low;
  logic [7:0] next_timer_reload_low;
  logic [2:0] timer_control;
  logic [2:0] next_timer_control;
  logic [5:0] timer_clock_control;
  logic [5:0] next_timer_clock_control;
  logic reload_load;

  always_comb begin
    next_tone_control = tone_control;
    next_infrared_carrier_control = infrared_carrier_control;
    next_second_pwm_control = second_pwm_control;
    next_second_pwm_duty_low = second_pwm_duty_low;
    next_third_pwm_control = third_pwm_control;
    next_third_pwm_duty_low = third_pwm_duty_low;
    next_third_pwm_duty_high = third_pwm_duty_high;
    next_timer_high_bits = timer_high_bits;
    next_timer_reload_low = timer_reload_low;
    next_timer_control = timer_control;
    next_timer_clock_control = timer_clock_control;
    reload_load = 1'b0;
    if (reg_wr_in) begin
      if (reg_addr_in == `TIP_OFS_RELOAD) begin
        next_timer_reload_low = reg_wdata_in;
        reload_load = 1'b1;
      end else if (reg_addr_in == `TIP_OFS_TCTRL) begin
        next_timer_control = reg_wdata_in[2:0];
      end else if (reg_addr_in == `TIP_OFS_TCLK) begin
        next_timer_clock_control = reg_wdata_in[5:0];
      end else if (reg_addr_in == `TIP_OFS_TONE) begin
        next_tone_control = reg_wdata_in;
      end else if (reg_addr_in == `TIP_OFS_IR) begin
        next_infrared_carrier_control = reg_wdata_in[2:0];
      end else if (reg_addr_in == `TIP_OFS_P2CTL) begin
        next_second_pwm_control = reg_wdata_in;
      end else if (reg_addr_in == `TIP_OFS_P2DUTY) begin
        next_second_pwm_duty_low = reg_wdata_in;
      end else if (reg_addr_in == `TIP_OFS_THIGH) begin
        next_timer_high_bits = reg_wdata_in;
      end else if (reg_addr_in == `TIP_OFS_P3CTL) begin
        next_third_pwm_control = reg_wdata_in;
      end else if (reg_addr_in == `TIP_OFS_P3DUTY) begin
        next_third_pwm_duty_low = reg_wdata_in;
      end else if (reg_addr_in == `TIP_OFS_P3DHI) begin
        next_third_pwm_duty_high = reg_wdata_in[1:0];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      tone_control <= `TIP_RST_TONE;
      infrared_carrier_control <= `TIP_RST_IR;
      second_pwm_control <= `TIP_RST_ZERO;
      second_pwm_duty_low <= `TIP_RST_ZERO;
      third_pwm_control <= `TIP_RST_ZERO;
      third_pwm_duty_low <= `TIP_RST_ZERO;
      third_pwm_duty_high <= `TIP_RST_P3DHI;
      timer_high_bits <= `TIP_RST_ZERO;
      timer_reload_low <= `TIP_RST_ZERO;
      timer_control <= `TIP_RST_TCTRL;
      timer_clock_control <= `TIP_RST_TCLK;
    end else begin
      tone_control <= next_tone_control;
      infrared_carrier_control <= next_infrared_carrier_control;
      second_pwm_control <= next_second_pwm_control;
      second_pwm_duty_low <= next_second_pwm_duty_low;
      third_pwm_control <= next_third_pwm_control;
      third_pwm_duty_low <= next_third_pwm_duty_low;
      third_pwm_duty_high <= next_third_pwm_duty_high;
      timer_high_bits <= next_timer_high_bits;
      timer_reload_low <= next_timer_reload_low;
      timer_control <= next_timer_control;
      timer_clock_control <= next_timer_clock_control;
    end
  end

  // Fast oscillator as a 4 MHz average enable; jitter is one mclk period
  logic [6:0] fosc_acc;
  logic [6:0] next_fosc_acc;
  logic fosc_tick;
  logic next_fosc_tick;
  logic [7:0] fosc_sum;

  always_comb begin
    fosc_sum = {1'b0, fosc_acc} + {1'b0, `TIP_FOSC_STEP};
    next_fosc_tick = 1'b0;
    next_fosc_acc = fosc_sum[6:0];
    if (fosc_sum >= {1'b0, `TIP_FOSC_MOD}) begin
      next_fosc_acc = 7'(fosc_sum - {1'b0, `TIP_FOSC_MOD});
      next_fosc_tick = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      fosc_acc <= 7'h00;
      fosc_tick <= 1'b0;
    end else begin
      fosc_acc <= next_fosc_acc;
      fosc_tick <= next_fosc_tick;
    end
  end

  // External clock pin: three stages, level accepted when stages two and three agree
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;
  logic ext_level;
  logic next_ext_level;
  logic ext_edge;

  always_comb begin
    next_ext_level = (ext_s2 == ext_s3) ? ext_s3 : ext_level;
    ext_edge = 1'b0;
    if (next_ext_level != ext_level) begin
      ext_edge = timer_clock_control[`TIP_CLK_CE_BIT] ? ext_level : next_ext_level;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      ext_level <= 1'b0;
    end else begin
      ext_s1 <= ext_clk_in;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      ext_level <= next_ext_level;
    end
  end

  // Timer clock source
  tip_clk_src_e src;
  logic src_tick;

  always_comb begin
    if (second_pwm_control[`TIP_FAST_CLK_BIT]) begin
      src = TIP_SRC_FAST;
    end else if (timer_clock_control[`TIP_CLK_CS_BIT]) begin
      src = TIP_SRC_EXT;
    end else begin
      src = TIP_SRC_INSTR;
    end
    case (src)
      TIP_SRC_FAST: src_tick = fosc_tick;
      TIP_SRC_EXT: src_tick = ext_edge;
      default: src_tick = instr_clk_en_in;
    endcase
  end

  tip_tmr_cfg_s tmr_cfg;
  tip_tmr_state_s tmr;

  assign tmr_cfg = '{
    enable: timer_control[`TIP_TC_EN_BIT],
    reload_mode: timer_control[`TIP_TC_RL_BIT],
    one_shot: timer_control[`TIP_TC_OS_BIT],
    presc_off: timer_clock_control[`TIP_CLK_PSOFF_BIT],
    presc_sel: timer_clock_control[2:0],
    reload: {timer_high_bits[`TIP_THIGH_RLD_LSB+:2], timer_reload_low}
  };

  tip_timer u_timer (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .tick_in(src_tick),
    .cfg_in(tmr_cfg),
    .load_in(reload_load),
    .state_out(tmr)
  );

  tip_ir_cfg_s ir_cfg;

  assign ir_cfg = '{
    enable: infrared_carrier_control[`TIP_IR_EN_BIT],
    rate_57k: infrared_carrier_control[`TIP_IR_RATE_BIT],
    polarity: infrared_carrier_control[`TIP_IR_POL_BIT]
  };

  tip_carrier u_carrier (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .fosc_tick_in(fosc_tick),
    .cfg_in(ir_cfg),
    .pin_data_in(ir_pin_data_in),
    .carrier_out(carrier_out)
  );

  // Tone: a counter bit is already a square wave at the chosen rate
  logic tone_src;
  logic next_tone;

  always_comb begin
    if (tone_control[3]) begin
      tone_src = tmr.count[tone_control[2:0]];
    end else begin
      tone_src = tmr.presc[tone_control[2:0]];
    end
    next_tone = tone_control[`TIP_TONE_EN_BIT] & tone_src;
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      port_pin_b2_out <= 1'b0;
    end else begin
      port_pin_b2_out <= next_tone;
    end
  end

  assign port_pin_b2_sel_out = tone_control[`TIP_TONE_EN_BIT];

  // PWM channels: index 0 is the second PWM, index 1 the third
  logic [9:0] duty [NUM_PWM];
  logic [NUM_PWM-1:0] active_low;
  logic [NUM_PWM-1:0] pwm_wave;
  logic [NUM_PWM-1:0] next_pwm_wave;

  assign duty[0] = {timer_high_bits[`TIP_THIGH_P2D_LSB+:2], second_pwm_duty_low};
  assign duty[1] = {third_pwm_duty_high, third_pwm_duty_low};
  assign active_low[0] = second_pwm_control[`TIP_PWM_AL_BIT];
  assign active_low[1] = third_pwm_control[`TIP_PWM_AL_BIT];

  generate
    for (genvar i = 0; i < NUM_PWM; i++) begin : g_pwm
      always_comb begin
        // Period restarts with each timer reload, since it follows the count
        next_pwm_wave[i] = (tmr.count < duty[i]) ^ active_low[i];
      end

      always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
          pwm_wave[i] <= 1'b0;
        end else begin
          pwm_wave[i] <= next_pwm_wave[i];
        end
      end
    end
  endgenerate

  assign port_pin_b0_out = pwm_wave[0];
  assign port_pin_b0_sel_out = second_pwm_control[`TIP_PWM_PIN_BIT];
  assign port_pin_b3_out = pwm_wave[1];
  assign port_pin_b3_sel_out = third_pwm_control[`TIP_PWM_PIN_BIT];

  // Read port: data valid only in the cycle after the strobe
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd_in) begin
      if (reg_addr_in == `TIP_OFS_RELOAD) begin
        next_rdata = tmr.count[7:0];
      end else if (reg_addr_in == `TIP_OFS_TCTRL) begin
        next_rdata = {5'h00, timer_control};
      end else if (reg_addr_in == `TIP_OFS_TCLK) begin
        next_rdata = {2'h0, timer_clock_control};
      end else if (reg_addr_in == `TIP_OFS_STATUS) begin
        next_rdata = {port_pin_b2_out, carrier_out, pwm_wave, tmr.running,
                      1'b0, tmr.count[9:8]};
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

endmodule // tip_top

// *** test/tb_top.sv ***
`timescale 1ns/10ps

module tb_top;
  logic mclk_in;
  logic rst_n_in;
  logic [4:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [7:0] reg_rdata_out;
  logic instr_clk_en_in;
  logic ext_clk_in;
  logic ir_pin_data_in;
  logic port_pin_b2_out;
  logic port_pin_b2_sel_out;
  logic carrier_out;
  logic port_pin_b0_out;
  logic port_pin_b0_sel_out;
  logic port_pin_b3_out;
  logic port_pin_b3_sel_out;
  logic clr = 1'b0;
  logic ext_run = 1'b0;
  logic [2:0] ediv = 3'h0;
  logic [7:0] rv;
  int hi[4];
  int rise[4];
  int n_mismatch = 0;
  int n_tests = 0;
  // Reset reads {address, value}
  logic [12:0] rst_rows[7] = '{{5'h00, 8'h00}, {5'h01, 8'h00}, {5'h02, 8'h3f},
    {5'h05, 8'h00}, {5'h06, 8'h00}, {5'h15, 8'h08}, {5'h1f, 8'h00}};
  // Carrier rows {control, pin data, rises, high cycles} over 960 cycles
  int ir_rows[7][4] = '{'{1, 1, 4, 480}, '{3, 1, 6, 480}, '{5, 1, 0, 0}, '{5, 0, 4, 480},
    '{7, 0, 6, 480}, '{0, 1, 0, 0}, '{1, 0, 0, 0}};

  tip_top uut (.*);
  tip_loads loads (.mclk_in, .clr_in(clr),
    .lvl_in({carrier_out, port_pin_b3_out, port_pin_b2_out, port_pin_b0_out}),
    .sel_in({1'b1, port_pin_b3_sel_out, port_pin_b2_sel_out, port_pin_b0_sel_out}),
    .hi_out(hi), .rise_out(rise));

  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end

  // External clock pin, period 10 cycles, still unless running
  always @(posedge mclk_in) begin
    ediv <= (ediv == 3'h4) ? 3'h0 : ediv + 3'h1;
    if (ediv == 3'h4 && ext_run) begin
      ext_clk_in <= ~ext_clk_in;
    end
  end

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %0h, want %0h", $time, seen, exp);
    end
  endtask

  // Whole-period windows make the counts exact
  task automatic meas(input int n);
    @(posedge mclk_in);
    clr <= 1'b1;
    @(posedge mclk_in);
    clr <= 1'b0;
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_n_in = 1'b0;
    reg_addr_in = 5'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    instr_clk_en_in = 1'b0;
    ext_clk_in = 1'b0;
    ir_pin_data_in = 1'b0;
    repeat (3) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    foreach (rst_rows[i]) begin
      rd(rst_rows[i][12:8], rv);
      chk(rv, rst_rows[i][7:0]);
    end
    wr(5'h1f, 8'hff);
    rd(5'h02, rv);
    chk(rv, 8'h3f);
    // PWM: reload 10, both duties 4, timer stepped every cycle
    instr_clk_en_in <= 1'b1;
    wr(5'h02, 8'h08);
    wr(5'h00, 8'h0a);
    wr(5'h0c, 8'h04);
    wr(5'h13, 8'h04);
    wr(5'h0a, 8'h80);
    wr(5'h11, 8'hc0);
    wr(5'h01, 8'h03);
    meas(110);
    chk(hi[0], 40);
    chk(hi[2], 70);
    wr(5'h0a, 8'hc0);
    meas(110);
    chk(hi[0], 70);
    wr(5'h0a, 8'h40);
    wr(5'h11, 8'h40);
    meas(110);
    chk(hi[0], 0);
    chk(hi[2], 0);
    wr(5'h0a, 8'h80);
    wr(5'h11, 8'hc0);
    wr(5'h10, 8'h14);
    wr(5'h00, 8'h0a);
    meas(267);
    chk(hi[0], 260);
    chk(hi[2], 263);
    wr(5'h10, 8'h00);
    wr(5'h00, 8'h0a);
    @(posedge mclk_in) instr_clk_en_in <= 1'b0;
    wr(5'h0a, 8'h88);
    meas(275);
    chk(hi[0] >= 95 && hi[0] <= 105, 1);
    wr(5'h0a, 8'h80);
    wr(5'h02, 8'h28);
    @(posedge mclk_in) ext_run <= 1'b1;
    repeat (30) @(posedge mclk_in);
    meas(1100);
    chk(hi[0], 400);
    // Falling-edge counting on the external pin
    wr(5'h02, 8'h38);
    repeat (30) @(posedge mclk_in);
    meas(1100);
    chk(hi[0], 400);
    @(posedge mclk_in) ext_run <= 1'b0;
    // Tone from timer bits, then prescaler bits, timer wrapping through 1024 counts
    @(posedge mclk_in) instr_clk_en_in <= 1'b1;
    wr(5'h02, 8'h08);
    wr(5'h01, 8'h01);
    repeat (20) @(posedge mclk_in);
    for (int k = 0; k < 8; k++) begin
      wr(5'h05, 8'(8'h88 | k));
      meas(1024);
      chk(rise[1], 512 >> k);
    end
    wr(5'h02, 8'h07);
    for (int k = 0; k < 8; k++) begin
      wr(5'h05, 8'(8'h80 | k));
      meas(256);
      chk(rise[1], 128 >> k);
    end
    wr(5'h05, 8'h00);
    meas(256);
    chk(hi[1], 0);
    chk(port_pin_b2_out, 1'b0);
    // One-shot: count stops at zero, second PWM then active
    wr(5'h02, 8'h08);
    wr(5'h01, 8'h05);
    wr(5'h00, 8'h05);
    repeat (20) @(posedge mclk_in);
    rd(5'h15, rv);
    chk(rv, 8'h10);
    rd(5'h00, rv);
    chk(rv, 8'h00);
    // Carrier with the timer clock stopped
    @(posedge mclk_in) instr_clk_en_in <= 1'b0;
    foreach (ir_rows[i]) begin
      @(posedge mclk_in) ir_pin_data_in <= ir_rows[i][1][0];
      wr(5'h06, 8'(ir_rows[i][0]));
      repeat (250) @(posedge mclk_in);
      meas(960);
      chk(rise[3], ir_rows[i][2]);
      chk(hi[3], ir_rows[i][3]);
    end
    // Reset in mid-run with pins active
    wr(5'h06, 8'h01);
    wr(5'h05, 8'h80);
    @(posedge mclk_in) rst_n_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1;
    chk({port_pin_b0_out, port_pin_b2_out, port_pin_b3_out, carrier_out, port_pin_b0_sel_out,
      port_pin_b2_sel_out, port_pin_b3_sel_out}, 0);
    @(posedge mclk_in) rst_n_in <= 1'b1;
    rd(5'h02, rv);
    chk(rv, 8'h3f);
    results();
  end
endmodule // tb_top

// *** test/tip_loads.sv ***
`timescale 1ns/10ps

module tip_loads (
  // Clock and window clear
  input wire logic mclk_in,
  input wire logic clr_in,
  // Pin drivers: b0, b2, b3, carrier
  input wire logic [3:0] lvl_in,
  input wire logic [3:0] sel_in,
  // Counts over the window
  output int hi_out[4],
  output int rise_out[4]
);
  logic [3:0] pin;
  logic [3:0] prev;

  // Pins not driven fall to the pull-low level
  assign pin = lvl_in & sel_in;

  always_ff @(posedge mclk_in) begin
    prev <= pin;
    for (int i = 0; i < 4; i++) begin
      if (clr_in) begin
        hi_out[i] <= 0;
        rise_out[i] <= 0;
      end else begin
        hi_out[i] <= hi_out[i] + int'(pin[i]);
        rise_out[i] <= rise_out[i] + int'(pin[i] & ~prev[i]);
      end
    end
  end
endmodule // tip_loads

// *** test/tip_top_sva.sv ***
`timescale 1ns/10ps
`include "tip_cfg.svh"

module tip_top_sva (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Register port and carrier gate
  input wire logic [`TIP_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic ir_pin_data_in,
  // Pins
  input wire logic port_pin_b2_out,
  input wire logic port_pin_b2_sel_out,
  input wire logic carrier_out,
  input wire logic port_pin_b0_out,
  input wire logic port_pin_b0_sel_out,
  input wire logic port_pin_b3_out,
  input wire logic port_pin_b3_sel_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  tone_sel_a: assert property (reg_wr_in && reg_addr_in == `TIP_OFS_TONE
    |=> port_pin_b2_sel_out == $past(reg_wdata_in[7])) else $error("tone enable not taken");
  b0_sel_a: assert property (reg_wr_in && reg_addr_in == `TIP_OFS_P2CTL
    |=> port_pin_b0_sel_out == $past(reg_wdata_in[7])) else $error("b0 enable not taken");
  b3_sel_a: assert property (reg_wr_in && reg_addr_in == `TIP_OFS_P3CTL
    |=> port_pin_b3_sel_out == $past(reg_wdata_in[7])) else $error("b3 enable not taken");
  sel_hold_a: assert property (!reg_wr_in |=> $stable({port_pin_b0_sel_out,
    port_pin_b2_sel_out, port_pin_b3_sel_out})) else $error("pin enable moved");
  tone_rest_a: assert property (!port_pin_b2_sel_out ##1 !port_pin_b2_sel_out
    |-> !port_pin_b2_out) else $error("tone not resting low");
  carrier_half_a: assert property ($rose(carrier_out) |-> ##[1:125] !carrier_out)
    else $error("carrier high phase too long");
  gate_hold_a: assert property (carrier_out && $past(carrier_out) && !$past(reg_wr_in, 2)
    |-> $past(ir_pin_data_in) == $past(ir_pin_data_in, 2)) else $error("carrier ungated");
  rst_quiet_a: assert property ($rose(rst_n_in) |-> !(port_pin_b0_out || port_pin_b2_out
    || port_pin_b3_out || carrier_out)) else $error("outputs busy after reset");

  cover property ($rose(port_pin_b2_out));
  cover property ($rose(carrier_out));
  cover property (port_pin_b0_sel_out && $rose(port_pin_b0_out));
  cover property (port_pin_b3_sel_out && $rose(port_pin_b3_out));
endmodule // tip_top_sva

bind tip_top tip_top_sva chk (.mclk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .ir_pin_data_in, .port_pin_b2_out, .port_pin_b2_sel_out, .carrier_out, .port_pin_b0_out,
  .port_pin_b0_sel_out, .port_pin_b3_out, .port_pin_b3_sel_out);
